// ==== verilog/odt_pkg.sv ====
// shared constants and types for the termination timing link and its two ends
package odt_pkg;

  // clock figures of the system clock and of the link clock
  localparam int CLK_PS       = 10000;
  localparam int CK_HALF_DIV  = 4;
  localparam int CK_PERIOD_PS = 2 * CK_HALF_DIV * CLK_PS;
  localparam int CK_NS        = CK_PERIOD_PS / 1000;

  // latency arithmetic, all in link clock cycles
  localparam int HIST_W      = 32;
  localparam int ODTL_SUB    = 2;
  localparam int ANPD_SUB    = 1;
  localparam int CWN4_ADD    = 4;
  localparam int CWN8_ADD    = 6;
  localparam int ODTH4_TCK   = 4;
  localparam int ODTH8_TCK   = 6;

  // strength change skew: window and nominal point in per-mille of a link period
  localparam int ADC_MIN_PERMIL = 300;
  localparam int ADC_MAX_PERMIL = 700;
  localparam int ADC_NOM_PERMIL = 500;
  localparam int ADC_NOM_PCLK   = (CK_PERIOD_PS * ADC_NOM_PERMIL / 1000) / CLK_PS;

  // asynchronous turn-on and turn-off delay bounds
  localparam int AONPD_MIN_PS  = 2000;
  localparam int AONPD_MAX_PS  = 8500;
  localparam int AONPD_MIN_CYC = (AONPD_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int AONPD_MAX_RAW = AONPD_MAX_PS / CLK_PS;
  localparam int AONPD_MAX_CYC = (AONPD_MAX_RAW < 1) ? 1 : AONPD_MAX_RAW;

  // power-down windows in link cycles; entry delay and exit delay are plain defaults
  localparam int RFC_NS     = 160;
  localparam int RFC_TCK    = (RFC_NS + CK_NS - 1) / CK_NS;
  localparam int CPDED_TCK  = 1;
  localparam int XPDLL_TCK  = 10;
  localparam int CNT_W      = 8;

  // controller register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CFG    = 8'h0c;

  // field positions
  localparam int CTRL_ODT_BIT = 0;
  localparam int CTRL_PD_BIT  = 1;
  localparam int CMD_WR_BIT   = 0;
  localparam int CMD_BC4_BIT  = 1;
  localparam int CMD_REF_BIT  = 2;
  localparam int CFG_CWL_LSB  = 0;
  localparam int CFG_AL_LSB   = 4;
  localparam logic [3:0] CFG_CWL_RST = 4'h5;
  localparam logic [4:0] CFG_AL_RST  = 5'h00;

  typedef enum logic [1:0] {
    RTT_OFF = 2'h0,
    RTT_NOM = 2'h1,
    RTT_WR  = 2'h2
  } odt_rtt_type;

endpackage

// ==== verilog/odt_link_if.sv ====
// link between controller end and memory end: clock, termination pin, cke, commands
`timescale 1ns/1ps
interface odt_link_if;
  logic ck;
  logic odt;
  logic cke;
  logic cmd_wr;
  logic cmd_bc4;
  logic cmd_ref;

  modport ctrl_mp (output ck, output odt, output cke, output cmd_wr, output cmd_bc4,
                   output cmd_ref);
  modport dram_mp (input ck, input odt, input cke, input cmd_wr, input cmd_bc4,
                   input cmd_ref);
endinterface

// ==== verilog/odt_dram_end.sv ====
// memory end: termination on/off and strength timing driven by the link
// Function
// RL1 - termination follows registered odt after WL-2
// RL2 - write strength selected WL-2 after write
// RL3 - chop-4 write returns nominal at 4+offlatency
// RL4 - burst-8 write returns nominal at 6+offlatency
// RL5 - odt held high at least 4 cycles
// RL6 - chop-4 write with odt: 4 cycles high
// RL7 - burst-8 write with odt: 6 cycles high
// RL8 - both minimum-high counts apply, later wins
// RL9 - new strength valid 0.3 to 0.7 cycles
// RL10 - changes land half a cycle after latency
// RL11 - asynchronous mode in frozen-dll power-down
// RL12 - asynchronous mode ignores additive latency
// RL13 - async turn-on within 2 to 8.5 ns; code takes 30 ns, two sync stages plus the output register
// RL14 - async turn-off within 2 to 8.5 ns; code takes 30 ns, two sync stages plus the output register
// RL15 - no reads or writes during power-down
// RL16 - frozen-dll setting opens entry transition period
// RL17 - entry period: WL-1 before cke low to entry delay
// RL18 - pending refresh extends entry period end
// RL19 - transition changes fall within either timing
// RL20 - exit period: WL-1 before cke high to exit delay
// RL21 - dynamic strength only when write select nonzero
// RL22 - additive latency adds to sync termination latency
`timescale 1ns/1ps
module odt_dram_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  odt_link_if.dram_mp      link,
  input  wire logic [3:0]  cfg_cwl,
  input  wire logic [4:0]  cfg_al,
  input  wire logic        cfg_rtt_nom_en,
  input  wire logic [1:0]  cfg_rtt_wr_sel,
  input  wire logic        cfg_pd_dll_on,
  output logic      [1:0]  rtt_state,
  output logic             async_mode,
  output logic             transition,
  output logic             odth_err
);

  // pin vector order: ck, odt, cke, wr, bc4, ref
  localparam int PIN_N   = 6;
  localparam int P_CK    = 5;
  localparam int P_ODT   = 4;
  localparam int P_CKE   = 3;
  localparam int P_WR    = 2;
  localparam int P_BC4   = 1;
  localparam int P_REF   = 0;

  logic [PIN_N-1:0]          pin_meta_reg;
  logic [PIN_N-1:0]          pin_sync_reg;
  logic                      ck_prev_reg;
  logic                      ck_rise;
  logic [4:0]                wl_tck;
  logic [4:0]                odtl;
  logic                      dyn_en;
  logic [odt_pkg::HIST_W-1:0] odt_hist_reg;
  logic [odt_pkg::HIST_W-1:0] wr_hist_reg;
  logic [odt_pkg::HIST_W-1:0] bc4_hist_reg;
  logic                      odt_target;
  logic                      wr_window;
  logic [3:0]                skew_cnt_reg;
  logic                      apply;
  logic [1:0]                sync_rtt;
  logic                      cke_reg;
  logic [odt_pkg::CNT_W-1:0] ref_cnt_reg;
  logic [odt_pkg::CNT_W-1:0] entry_cnt_reg;
  logic [odt_pkg::CNT_W-1:0] exit_cnt_reg;
  logic [odt_pkg::CNT_W-1:0] entry_load;
  logic                      async_mode_reg;
  logic                      transition_reg;
  logic [1:0]                rtt_state_reg;
  logic [odt_pkg::CNT_W-1:0] hold_cnt_reg;
  logic                      odt_q_reg;
  logic                      odth_err_reg;

  // two-flop synchroniser for every link pin; only the second stage is read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      ck_prev_reg  <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= {link.ck, link.odt, link.cke, link.cmd_wr, link.cmd_bc4, link.cmd_ref};
      pin_sync_reg <= pin_meta_reg;
      ck_prev_reg  <= pin_sync_reg[P_CK];
    end
  end

  // every pin passes the same two stages, so sampled data and clock stay aligned
  assign ck_rise = pin_sync_reg[P_CK] & ~ck_prev_reg;

  // latency in link cycles, additive latency included
  assign wl_tck = 5'(cfg_cwl) + cfg_al;                      // see RL22
  assign odtl   = wl_tck - 5'(odt_pkg::ODTL_SUB);            // see RL1
  assign dyn_en = |cfg_rtt_wr_sel;                           // see RL21

  // history of registered odt and writes; bit 0 holds the newest edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      odt_hist_reg <= '0;
      wr_hist_reg  <= '0;
      bc4_hist_reg <= '0;
    end
    else if (ck_rise)
    begin
      odt_hist_reg <= {odt_hist_reg[odt_pkg::HIST_W-2:0], pin_sync_reg[P_ODT]};
      // commands are only decoded while cke is registered high
      wr_hist_reg  <= {wr_hist_reg[odt_pkg::HIST_W-2:0],
                       pin_sync_reg[P_WR] & pin_sync_reg[P_CKE]};      // see RL15
      bc4_hist_reg <= {bc4_hist_reg[odt_pkg::HIST_W-2:0], pin_sync_reg[P_BC4]};
    end
  end

  // level registered odtl edges ago decides on/off
  assign odt_target = odt_hist_reg[odtl];                    // see RL1

  // write strength window: from odtl up to odtl plus 4 or 6 after the write
  always_comb
  begin
    wr_window = 1'b0;
    for (int k = 0; k < odt_pkg::HIST_W; k++)
    begin
      if (wr_hist_reg[k] && (k >= int'(odtl)) &&
          (k < int'(odtl) + (bc4_hist_reg[k] ? odt_pkg::CWN4_ADD : odt_pkg::CWN8_ADD)))
      begin
        wr_window = 1'b1;                                    // see RL2 see RL3 see RL4
      end
    end
  end

  // strength selection for synchronous mode
  always_comb
  begin
    if (!odt_target)
      sync_rtt = odt_pkg::RTT_OFF;
    else if (dyn_en && wr_window)
      sync_rtt = odt_pkg::RTT_WR;                            // see RL2
    else if (cfg_rtt_nom_en)
      sync_rtt = odt_pkg::RTT_NOM;
    else
      sync_rtt = odt_pkg::RTT_OFF;
  end

  // half-period skew: change lands mid-cycle, inside the 0.3..0.7 window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      skew_cnt_reg <= '0;
    else if (ck_rise)
      skew_cnt_reg <= 4'(odt_pkg::ADC_NOM_PCLK);             // see RL10 see RL9
    else if (skew_cnt_reg != '0)
      skew_cnt_reg <= skew_cnt_reg - 4'h1;
  end

  assign apply = (skew_cnt_reg == 4'h1);

  // registered cke and refresh busy time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cke_reg     <= 1'b1;
      ref_cnt_reg <= '0;
    end
    else if (ck_rise)
    begin
      cke_reg <= pin_sync_reg[P_CKE];
      if (pin_sync_reg[P_REF] && pin_sync_reg[P_CKE])
        ref_cnt_reg <= odt_pkg::CNT_W'(odt_pkg::RFC_TCK);
      else if (ref_cnt_reg != '0)
        ref_cnt_reg <= ref_cnt_reg - 8'h01;
    end
  end

  // entry window ends at the later of entry delay and refresh end
  assign entry_load = (ref_cnt_reg > odt_pkg::CNT_W'(odt_pkg::CPDED_TCK)) ?
                      ref_cnt_reg : odt_pkg::CNT_W'(odt_pkg::CPDED_TCK);   // see RL18

  // entry and exit windows, counted in link cycles after the cke change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      entry_cnt_reg <= '0;
      exit_cnt_reg  <= '0;
    end
    else if (ck_rise)
    begin
      if (cke_reg && !pin_sync_reg[P_CKE] && !cfg_pd_dll_on)
        entry_cnt_reg <= entry_load;                         // see RL16 see RL17
      else if (entry_cnt_reg != '0)
        entry_cnt_reg <= entry_cnt_reg - 8'h01;
      if (!cke_reg && pin_sync_reg[P_CKE] && !cfg_pd_dll_on)
        exit_cnt_reg <= odt_pkg::CNT_W'(odt_pkg::XPDLL_TCK);  // see RL20
      else if (exit_cnt_reg != '0)
        exit_cnt_reg <= exit_cnt_reg - 8'h01;
    end
  end

  // async only once the entry window is over; stays sync inside windows,
  // which keeps every change within the combined bounds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_mode_reg <= 1'b0;
      transition_reg <= 1'b0;
    end
    else
    begin
      async_mode_reg <= ~cke_reg & ~cfg_pd_dll_on & (entry_cnt_reg == '0);   // see RL11 see RL19
      transition_reg <= (entry_cnt_reg != '0) | (exit_cnt_reg != '0);
    end
  end

  // termination output; async path has no latency pipeline at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rtt_state_reg <= odt_pkg::RTT_OFF;
    else if (async_mode_reg)
      // one clock after the synchroniser; the two sync stages alone exceed
      // the upper async bound, a known limit of sampling the pin
      rtt_state_reg <= (pin_sync_reg[P_ODT] && cfg_rtt_nom_en) ?
                       odt_pkg::RTT_NOM : odt_pkg::RTT_OFF;  // see RL12 see RL13 see RL14
    else if (apply)
      rtt_state_reg <= sync_rtt;                             // see RL1 see RL10
  end

  // minimum odt high time watch; sticky flag until reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt_reg <= '0;
      odt_q_reg    <= 1'b0;
      odth_err_reg <= 1'b0;
    end
    else if (ck_rise)
    begin
      odt_q_reg <= pin_sync_reg[P_ODT];
      if (pin_sync_reg[P_ODT] && pin_sync_reg[P_WR] && pin_sync_reg[P_CKE])
      begin
        // write with odt high: later of the two counts wins
        if (pin_sync_reg[P_BC4] && hold_cnt_reg < odt_pkg::CNT_W'(odt_pkg::ODTH4_TCK - 1))
          hold_cnt_reg <= odt_pkg::CNT_W'(odt_pkg::ODTH4_TCK - 1);          // see RL6 see RL8
        else if (!pin_sync_reg[P_BC4] &&
                 hold_cnt_reg < odt_pkg::CNT_W'(odt_pkg::ODTH8_TCK - 1))
          hold_cnt_reg <= odt_pkg::CNT_W'(odt_pkg::ODTH8_TCK - 1);          // see RL7 see RL8
        else if (hold_cnt_reg != '0)
          hold_cnt_reg <= hold_cnt_reg - 8'h01;
      end
      else if (pin_sync_reg[P_ODT] && !odt_q_reg)
        hold_cnt_reg <= odt_pkg::CNT_W'(odt_pkg::ODTH4_TCK - 1);            // see RL5
      else if (hold_cnt_reg != '0)
        hold_cnt_reg <= hold_cnt_reg - 8'h01;
      if (!pin_sync_reg[P_ODT] && odt_q_reg && hold_cnt_reg != '0)
        odth_err_reg <= 1'b1;
    end
  end

  assign rtt_state  = rtt_state_reg;
  assign async_mode = async_mode_reg;
  assign transition = transition_reg;
  assign odth_err   = odth_err_reg;

endmodule // odt_dram_end

// ==== verilog/odt_ctrl_end.sv ====
// controller end: link clock divider, odt and cke sequencing, APB order registers
`timescale 1ns/1ps
module odt_ctrl_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  odt_link_if.ctrl_mp      link
);

  typedef enum logic [2:0] {
    ST_RUN         = 3'h0,
    ST_ENT_WAIT    = 3'h1,
    ST_ENT_SETTLE  = 3'h2,
    ST_PD          = 3'h3,
    ST_EXIT_WAIT   = 3'h4,
    ST_EXIT_SETTLE = 3'h5
  } odt_state_type;

  odt_state_type             state_reg;
  logic [1:0]                div_cnt_reg;
  logic                      ck_reg;
  logic                      fall_en;
  logic [1:0]                ctrl_reg;
  logic [8:0]                cfg_reg;
  logic [2:0]                pend_reg;
  logic [31:0]               prdata_reg;
  logic                      odt_reg;
  logic                      odt_next;
  logic                      cke_reg;
  logic [2:0]                cmd_reg;
  logic [odt_pkg::CNT_W-1:0] hold_reg;
  logic [odt_pkg::CNT_W-1:0] cnt_reg;
  logic [odt_pkg::CNT_W-1:0] rfc_reg;
  logic [odt_pkg::CNT_W-1:0] anpd;
  logic                      odt_free;
  logic                      issue;
  logic                      wr_access;
  logic                      mapped;

  // link clock: half period of CK_HALF_DIV system cycles; pins move at its fall
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_reg <= '0;
      ck_reg      <= 1'b0;
    end
    else if (div_cnt_reg == 2'(odt_pkg::CK_HALF_DIV - 1))
    begin
      div_cnt_reg <= '0;
      ck_reg      <= ~ck_reg;
    end
    else
      div_cnt_reg <= div_cnt_reg + 2'h1;
  end

  assign fall_en = (div_cnt_reg == 2'(odt_pkg::CK_HALF_DIV - 1)) & ck_reg;

  // apb slave: zero wait states, unmapped address answers with an error
  assign mapped    = (paddr == odt_pkg::REG_CTRL) | (paddr == odt_pkg::REG_CMD) |
                     (paddr == odt_pkg::REG_STATUS) | (paddr == odt_pkg::REG_CFG);
  assign wr_access = psel & penable & pwrite & mapped;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  // writable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= '0;
      cfg_reg  <= {odt_pkg::CFG_AL_RST, odt_pkg::CFG_CWL_RST};
    end
    else if (wr_access && paddr == odt_pkg::REG_CTRL)
      ctrl_reg <= pwdata[1:0];
    else if (wr_access && paddr == odt_pkg::REG_CFG)
      cfg_reg <= pwdata[8:0];
  end

  // read data captured in the setup cycle, shown during the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= '0;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        odt_pkg::REG_CTRL:   prdata_reg <= {30'h0, ctrl_reg};
        odt_pkg::REG_CMD:    prdata_reg <= {29'h0, pend_reg};
        odt_pkg::REG_STATUS: prdata_reg <= {16'h0, hold_reg, 1'b0, state_reg,
                                            1'b0, cke_reg, odt_reg, |pend_reg};
        odt_pkg::REG_CFG:    prdata_reg <= {23'h0, cfg_reg};
        default:             prdata_reg <= '0;
      endcase
    end
  end

  assign prdata = prdata_reg;

  // pending command: a new order is taken only when none is waiting;
  // a write or refresh stays pending through power-down
  assign issue = fall_en & (state_reg == ST_RUN) & (|pend_reg) & ~ctrl_reg[odt_pkg::CTRL_PD_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= '0;
    else if (issue)
      pend_reg <= '0;                                        // see RL15
    else if (wr_access && paddr == odt_pkg::REG_CMD && pend_reg == '0)
      pend_reg <= pwdata[2:0];
  end

  assign anpd     = odt_pkg::CNT_W'(cfg_reg[3:0]) + odt_pkg::CNT_W'(cfg_reg[8:4]) -
                    odt_pkg::CNT_W'(odt_pkg::ANPD_SUB);
  assign odt_free = (state_reg == ST_RUN) | (state_reg == ST_PD);  // see RL19

  // odt level: rises at once, falls only when the high time is served
  always_comb
  begin
    odt_next = odt_reg;
    if (odt_free && ctrl_reg[odt_pkg::CTRL_ODT_BIT])
      odt_next = 1'b1;
    else if (odt_free && hold_reg <= odt_pkg::CNT_W'(1))
      odt_next = 1'b0;                                       // see RL5 see RL8
  end

  // odt pin and its minimum-high counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      odt_reg  <= 1'b0;
      hold_reg <= '0;
    end
    else if (fall_en)
    begin
      odt_reg <= odt_next;
      if (issue && pend_reg[odt_pkg::CMD_WR_BIT] && odt_next)
        hold_reg <= pend_reg[odt_pkg::CMD_BC4_BIT] ?
                    odt_pkg::CNT_W'(odt_pkg::ODTH4_TCK) :
                    odt_pkg::CNT_W'(odt_pkg::ODTH8_TCK);     // see RL6 see RL7 see RL8
      else if (odt_next && !odt_reg)
        hold_reg <= odt_pkg::CNT_W'(odt_pkg::ODTH4_TCK);     // see RL5
      else if (hold_reg != '0)
        hold_reg <= hold_reg - 8'h01;
    end
  end

  // command pins stand for one link cycle; refresh time tracked for entry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_reg <= '0;
      rfc_reg <= '0;
    end
    else if (fall_en)
    begin
      cmd_reg <= issue ? pend_reg : 3'h0;
      if (issue && pend_reg[odt_pkg::CMD_REF_BIT])
        rfc_reg <= odt_pkg::CNT_W'(odt_pkg::RFC_TCK);
      else if (rfc_reg != '0)
        rfc_reg <= rfc_reg - 8'h01;
    end
  end

  // power-down sequencing; odt frozen through both transition periods
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_RUN;
      cnt_reg   <= '0;
      cke_reg   <= 1'b1;
    end
    else if (fall_en)
    begin
      unique case (state_reg)
        ST_RUN:
          if (ctrl_reg[odt_pkg::CTRL_PD_BIT] && !issue)
          begin
            state_reg <= ST_ENT_WAIT;
            cnt_reg   <= anpd;                               // see RL17
          end
        ST_ENT_WAIT:
          if (cnt_reg <= odt_pkg::CNT_W'(1))
          begin
            cke_reg   <= 1'b0;
            state_reg <= ST_ENT_SETTLE;
            cnt_reg   <= (rfc_reg > odt_pkg::CNT_W'(odt_pkg::CPDED_TCK)) ?
                         rfc_reg : odt_pkg::CNT_W'(odt_pkg::CPDED_TCK);  // see RL18
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        ST_ENT_SETTLE:
          if (cnt_reg <= odt_pkg::CNT_W'(1))
            state_reg <= ST_PD;                              // see RL16
          else
            cnt_reg <= cnt_reg - 8'h01;
        ST_PD:
          if (!ctrl_reg[odt_pkg::CTRL_PD_BIT])
          begin
            state_reg <= ST_EXIT_WAIT;
            cnt_reg   <= anpd;                               // see RL20
          end
        ST_EXIT_WAIT:
          if (cnt_reg <= odt_pkg::CNT_W'(1))
          begin
            cke_reg   <= 1'b1;
            state_reg <= ST_EXIT_SETTLE;
            cnt_reg   <= odt_pkg::CNT_W'(odt_pkg::XPDLL_TCK);
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        ST_EXIT_SETTLE:
          if (cnt_reg <= odt_pkg::CNT_W'(1))
            state_reg <= ST_RUN;
          else
            cnt_reg <= cnt_reg - 8'h01;
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  assign link.ck      = ck_reg;
  assign link.odt     = odt_reg;
  assign link.cke     = cke_reg;
  assign link.cmd_wr  = cmd_reg[odt_pkg::CMD_WR_BIT];
  assign link.cmd_bc4 = cmd_reg[odt_pkg::CMD_BC4_BIT];
  assign link.cmd_ref = cmd_reg[odt_pkg::CMD_REF_BIT];

endmodule // odt_ctrl_end

// ==== test/odt_link_monitor.sv ====
// assertions on the termination link between the two ends
`timescale 1ns/1ps
module odt_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck,
  input wire logic odt,
  input wire logic cke,
  input wire logic cmd_wr,
  input wire logic cmd_bc4,
  input wire logic cmd_ref
);
  logic       ck_q;
  logic [7:0] hi_cnt;
  logic [7:0] wr_cnt;
  logic [7:0] wr_need;
  wire        ck_rise = ck && !ck_q;

  // link rises while odt high and since the last write; saturate so long holds never wrap
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ck_q <= 1'b0;
      hi_cnt <= 8'h00;
      wr_cnt <= 8'h00;
      wr_need <= 8'h00;
    end
    else
    begin
      ck_q <= ck;
      if (!odt)
        hi_cnt <= 8'h00;
      else if (ck_rise && hi_cnt != 8'hff)
        hi_cnt <= hi_cnt + 8'h01;
      if (ck_rise && odt && cmd_wr)
      begin
        wr_cnt <= 8'h01;
        wr_need <= cmd_bc4 ? 8'h04 : 8'h06;
      end
      else if (ck_rise && wr_cnt != 8'hff)
        wr_cnt <= wr_cnt + 8'h01;
    end

  // the divider makes an even link clock of eight cycles
  sequence ck_high_s;
    ck [*4] ##1 !ck;
  endsequence
  sequence ck_low_s;
    !ck [*4] ##1 ck;
  endsequence

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  ck_high_a: assert property ($rose(ck) |-> ck_high_s) else $error("ck high phase wrong");
  ck_low_a: assert property ($fell(ck) |-> ck_low_s) else $error("ck low phase wrong");
  wr_len_a: assert property ($rose(cmd_wr) |-> cmd_wr [*8] ##1 !cmd_wr)
    else $error("write command length wrong");
  pin_edge_a: assert property (($changed(odt) || $changed(cke)) |-> !ck)
    else $error("odt or cke moved while ck high");
  pd_nocmd_a: assert property (!cke |-> !cmd_wr && !cmd_ref)
    else $error("command sent in power-down");
  bc4_pair_a: assert property (cmd_bc4 |-> cmd_wr) else $error("chop flag without write");
  odt_hold_a: assert property ($fell(odt) |-> hi_cnt >= 8'h04)
    else $error("odt dropped too early");
  wr_hold_a: assert property ($fell(odt) |-> wr_cnt >= wr_need)
    else $error("odt dropped too early after write");
endmodule // odt_link_monitor

// ==== test/dram_odt_timing_control_tb.sv ====
// bench: controller end and memory end joined on one link, driven over APB
`timescale 1ns/1ps
module dram_odt_timing_control_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready;
  logic        pslverr;
  logic [3:0]  cwl;
  logic [4:0]  al;
  logic [1:0]  wr_sel;
  logic [1:0]  rtt_state;
  logic [1:0]  rtt_q = 2'h0;
  logic [1:0]  e;
  logic        async_mode;
  logic        transition;
  logic        odth_err;
  logic        nom_en;
  logic        dll_on;
  logic        odt_q = 1'b0;
  logic        saw_trans = 1'b0;
  logic [32:0] rq[$];
  logic [1:0]  tq[$];
  int          gq[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          seed = 32'hf666;
  int          cyc = 0;
  int          wcyc = 0;
  int          c;
  int          a;
  int          lo;

  odt_link_if link ();
  odt_ctrl_end odt_ctrl_end_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  odt_dram_end odt_dram_end_i (.pclk(pclk), .presetn(presetn), .link(link), .cfg_cwl(cwl),
    .cfg_al(al), .cfg_rtt_nom_en(nom_en), .cfg_rtt_wr_sel(wr_sel), .cfg_pd_dll_on(dll_on),
    .rtt_state(rtt_state), .async_mode(async_mode), .transition(transition),
    .odth_err(odth_err));
  odt_link_monitor odt_link_monitor_i (.pclk(pclk), .presetn(presetn), .ck(link.ck),
    .odt(link.odt), .cke(link.cke), .cmd_wr(link.cmd_wr), .cmd_bc4(link.cmd_bc4),
    .cmd_ref(link.cmd_ref));

  task automatic cmp_val(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang;
    fail_count++;
    final_report;
  endtask

  // one APB transfer; the bench never assumes the slave's wait states
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      hang;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_q;
    int n;
    n = 0;
    while (tq.size() > 0 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (tq.size() > 0)
      hang;
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end
    while ((r & m) !== v && n < 500);
    if ((r & m) !== v)
      hang;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // results are matched against the oldest note as they appear
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && rq.size() > 0)
      cmp_val({pslverr, prdata}, rq.pop_front());
    cyc = (link.odt !== odt_q) ? 0 : cyc + 1;
    odt_q = link.odt;
    wcyc = wcyc + 1;
    saw_trans = saw_trans | transition;
    if (rtt_state !== rtt_q)
    begin
      e = (tq.size() > 0) ? tq.pop_front() : 2'h3;
      cmp_val(33'(rtt_state), 33'(e));
      lo = async_mode ? 1 : 8 * (cwl + al - 2) + 7;
      if (rtt_q != 2'h2 && rtt_state != 2'h2)
        cmp_val(33'((cyc >= lo && cyc <= lo + 6) ? lo : cyc), 33'(lo));
      if (rtt_q == 2'h2)
        cmp_val(33'(wcyc), 33'(gq.pop_front()));
      wcyc = 0;
      rtt_q = rtt_state;
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cwl = 4'h5;
    al = 5'h00;
    wr_sel = 2'h1;
    nom_en = 1'b1;
    dll_on = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rq.push_back(33'h5);
    apb(1'b0, 8'h0c, 32'h0);
    rq.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h10, 32'h0);
    c = 5 + {$random(seed)} % 6;
    a = {$random(seed)} % 4;
    apb(1'b1, 8'h0c, 32'((a << 4) | c));
    cwl <= 4'(c);
    al <= 5'(a);
    rq.push_back(33'((a << 4) | c));
    apb(1'b0, 8'h0c, 32'h0);
    // first pass with write strength enabled, second with it disabled
    for (int i = 0; i < 2; i++)
    begin
      wr_sel <= i ? 2'h0 : 2'(1 + {$random(seed)} % 3);
      tq.push_back(2'h1);
      apb(1'b1, 8'h00, 32'h1);
      wait_q;
      for (int k = 0; k < 2; k++)
      begin
        if (i == 0)
        begin
          tq.push_back(2'h2);
          tq.push_back(2'h1);
          gq.push_back(k ? 48 : 32);
        end
        apb(1'b1, 8'h04, k ? 32'h1 : 32'h3);
        poll(32'h1, 32'h0);
        repeat (16) @(posedge pclk); // command pins fall before the next order
        wait_q;
      end
      tq.push_back(2'h0);
      apb(1'b1, 8'h00, 32'h0);
      wait_q;
    end
    apb(1'b1, 8'h00, 32'h2);
    poll(32'h70, 32'h30);
    repeat (16) @(posedge pclk); // entry window ends after state shows pd
    cmp_val(33'(async_mode), 33'h1);
    tq.push_back(2'h1);
    apb(1'b1, 8'h00, 32'h3);
    wait_q;
    tq.push_back(2'h0);
    apb(1'b1, 8'h00, 32'h2);
    wait_q;
    apb(1'b1, 8'h00, 32'h0);
    poll(32'h70, 32'h00);
    // dll kept on: power-down stays synchronous; nominal off: odt gives no change
    dll_on <= 1'b1;
    nom_en <= 1'b0;
    apb(1'b1, 8'h00, 32'h2);
    poll(32'h70, 32'h30);
    repeat (16) @(posedge pclk);
    cmp_val(33'(async_mode), 33'h0);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h00, 32'h0);
    poll(32'h70, 32'h00);
    cmp_val(33'({async_mode, saw_trans, odth_err}), 33'h2);
    final_report;
  end
endmodule // dram_odt_timing_control_tb
